//--- src/mfp_defs.svh
`ifndef MFP_DEFS_SVH
`define MFP_DEFS_SVH

// ****************************************************************
// Clock, timing and field constants
// ****************************************************************

// System clock rate in MHz.
`define MFP_CLK_MHZ        125
// Shortest output-off period in microseconds; the selector doubles it per step.
`define MFP_OFF_BASE_US    500
// Width of the off-period down counter.
`define MFP_TMR_W          20
// Width of the off-period selector field.
`define MFP_SEL_W          2
// Number of output power transistors watched for overcurrent.
`define MFP_OC_LANES       6
// Width of the consecutive retry counter.
`define MFP_CNT_W          4
// Consecutive trips that end in lockout.
`define MFP_RETRY_LIMIT    4'h8
// Reset value of the retry counter.
`define MFP_CNT_RST        4'h0
// Reset value of every fault and status flag.
`define MFP_FLAG_RST       1'b0
// Reset value of the drive enable.
`define MFP_DRIVE_RST      1'b0

`endif

//--- src/mfp_pkg.sv
`include "mfp_defs.svh"

package mfp_pkg;

  // Overcurrent protection states, one-hot.
  typedef enum logic [2:0] {
    MFP_OC_RUN  = 3'b001,
    MFP_OC_WAIT = 3'b010,
    MFP_OC_HOLD = 3'b100
  } mfp_oc_e;

  // One bit per output power transistor.
  typedef logic [`MFP_OC_LANES-1:0] mfp_lane_t;

  // Off-period counter value.
  typedef logic [`MFP_TMR_W-1:0] mfp_tmr_t;

  // Retry counter value.
  typedef logic [`MFP_CNT_W-1:0] mfp_cnt_t;

  // Off-period selector.
  typedef logic [`MFP_SEL_W-1:0] mfp_sel_t;

endpackage

//--- src/mfp_if.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Signals between the synchroniser, the off timer and the core
// ****************************************************************
interface mfp_if;
  import mfp_pkg::*;

  logic       pump_low;
  logic       pump_ok;
  logic       temp_hot;
  logic       temp_cool;
  mfp_lane_t  oc;
  logic       tmr_start;
  mfp_sel_t   tmr_sel;
  logic       tmr_done;

  modport sync  (output pump_low, output pump_ok, output temp_hot, output temp_cool,
                 output oc);
  modport timer (input tmr_start, input tmr_sel, output tmr_done);
  modport core  (input pump_low, input pump_ok, input temp_hot, input temp_cool,
                 input oc, output tmr_start, output tmr_sel, input tmr_done);
endinterface

`default_nettype wire

//--- src/mfp_fault_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "mfp_defs.svh"

// ****************************************************************
// Two-stage synchroniser for the analog comparator indications
// ****************************************************************
module mfp_fault_sync (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               srst,
  // Raw comparator indications
  input wire logic               pump_low_raw,
  input wire logic               pump_ok_raw,
  input wire logic               temp_hot_raw,
  input wire logic               temp_cool_raw,
  input wire mfp_pkg::mfp_lane_t oc_raw,
  // Synchronised indications
  mfp_if.sync                    flt
);
  import mfp_pkg::*;

  localparam int NB = `MFP_OC_LANES + 4;

  logic [NB-1:0] raw;
  logic [NB-1:0] meta_r;
  logic [NB-1:0] sync_r;

  assign raw = {oc_raw, temp_cool_raw, temp_hot_raw, pump_ok_raw, pump_low_raw};

  // First stage feeds only the second stage.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  assign flt.pump_low  = sync_r[0];
  assign flt.pump_ok   = sync_r[1];
  assign flt.temp_hot  = sync_r[2];
  assign flt.temp_cool = sync_r[3];
  assign flt.oc        = sync_r[NB-1:4];

  property p_sync_delay;
    @(posedge sys_clk) disable iff (srst)
      !$past(srst, 2) |-> sync_r == $past(raw, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

endmodule

`default_nettype wire

//--- src/mfp_off_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mfp_defs.svh"

// ****************************************************************
// Output-off period timer
// ****************************************************************
module mfp_off_timer #(
  parameter int unsigned OFF_BASE_CYC = `MFP_OFF_BASE_US * `MFP_CLK_MHZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Start, selector and expiry
  mfp_if.timer     tmr
);
  import mfp_pkg::*;

  mfp_tmr_t cnt_r;
  logic     done_r;

  // Off period in cycles: the base period doubled once per selector step.
  function automatic mfp_tmr_t off_cycles(input mfp_sel_t sel);
    off_cycles = mfp_tmr_t'(OFF_BASE_CYC << sel);
  endfunction

  // Loads on start, counts down, pulses done on the last cycle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r  <= '0;
      done_r <= `MFP_FLAG_RST;
    end else if (tmr.tmr_start) begin
      cnt_r  <= off_cycles(tmr.tmr_sel);
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == mfp_tmr_t'(1));
      if (cnt_r != '0) begin
        cnt_r <= cnt_r - mfp_tmr_t'(1);
      end
    end
  end

  assign tmr.tmr_done = done_r;

  property p_load;
    @(posedge sys_clk) disable iff (srst)
      tmr.tmr_start |=> cnt_r == off_cycles($past(tmr.tmr_sel));
  endproperty
  a_load: assert property (p_load) else $error("off period not loaded");

endmodule

`default_nettype wire

//--- src/mfp_fault_prot.sv
`timescale 1ns/1ps
`default_nettype none
`include "mfp_defs.svh"

module mfp_fault_prot #(
  parameter int unsigned OFF_BASE_CYC = `MFP_OFF_BASE_US * `MFP_CLK_MHZ
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               srst,
  // Analog comparator indications
  input  wire logic               pump_low_raw,
  input  wire logic               pump_ok_raw,
  input  wire logic               temp_hot_raw,
  input  wire logic               temp_cool_raw,
  input  wire mfp_pkg::mfp_lane_t oc_raw,
  // Speed command and configuration
  input  wire logic               speed_command,
  input  wire logic               overcurrent_latch_select,
  input  wire mfp_pkg::mfp_sel_t  off_period_select,
  // Output stage control
  output logic                    drive_en,
  output logic                    stage_hiz,
  // Open-drain alert
  output logic                    alert_out,
  output logic                    alert_oe,
  // Status
  output logic                    overcurrent_shutdown,
  output logic                    overcurrent_lockout,
  output logic                    thermal_shutdown,
  output mfp_pkg::mfp_cnt_t       retry_count
);
  import mfp_pkg::*;

  // ****************************************************************
  // Declarations and sub-blocks
  // ****************************************************************

  mfp_if    flt ();
  mfp_oc_e  oc_r;
  mfp_oc_e  oc_nxt;
  mfp_cnt_t cnt_r;
  mfp_cnt_t cnt_nxt;
  logic     pump_uv_r;
  logic     pump_uv_nxt;
  logic     therm_r;
  logic     therm_nxt;
  logic     speed_d_r;
  logic     speed_reapply;
  logic     oc_any;
  logic     tmr_start;
  logic     drive_en_r;
  logic     stage_hiz_r;
  logic     alert_oe_r;
  logic     oc_sd_r;
  logic     oc_lock_r;
  logic     alert_out_r;

  // Comparator synchroniser.
  mfp_fault_sync u_sync (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .pump_low_raw  (pump_low_raw),
    .pump_ok_raw   (pump_ok_raw),
    .temp_hot_raw  (temp_hot_raw),
    .temp_cool_raw (temp_cool_raw),
    .oc_raw        (oc_raw),
    .flt           (flt.sync)
  );

  // Output-off period timer.
  mfp_off_timer #(
    .OFF_BASE_CYC (OFF_BASE_CYC)
  ) u_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .tmr     (flt.timer)
  );

  // Next value of the retry counter after one more trip.
  function automatic mfp_cnt_t bump(input mfp_cnt_t c);
    bump = mfp_cnt_t'(c + mfp_cnt_t'(1));
  endfunction

  // ****************************************************************
  // Speed command re-application
  // ****************************************************************

  // Stop-to-run edge of the speed command.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      speed_d_r <= `MFP_FLAG_RST;
    end else begin
      speed_d_r <= speed_command;
    end
  end

  assign speed_reapply = speed_command & ~speed_d_r;

  // ****************************************************************
  // Charge pump undervoltage and thermal shutdown
  // ****************************************************************

  // Trip indication wins over recovery indication when both are seen.
  always_comb begin
    pump_uv_nxt = pump_uv_r;
    if (flt.pump_low) begin
      pump_uv_nxt = 1'b1;
    end else if (flt.pump_ok) begin
      pump_uv_nxt = 1'b0;
    end
    therm_nxt = therm_r;
    if (flt.temp_hot) begin
      therm_nxt = 1'b1;
    end else if (flt.temp_cool) begin
      therm_nxt = 1'b0;
    end
  end

  // Self-recovering protection flags.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pump_uv_r <= `MFP_FLAG_RST;
      therm_r   <= `MFP_FLAG_RST;
    end else begin
      pump_uv_r <= pump_uv_nxt;
      therm_r   <= therm_nxt;
    end
  end

  // ****************************************************************
  // Overcurrent protection
  // ****************************************************************

  assign oc_any        = |flt.oc;
  assign flt.tmr_start = tmr_start;
  assign flt.tmr_sel   = off_period_select;

  // Trip, retry and lockout sequencing.
  always_comb begin
    oc_nxt    = oc_r;
    cnt_nxt   = cnt_r;
    tmr_start = 1'b0;
    case (oc_r)
      MFP_OC_RUN: begin
        if (oc_any) begin
          if (overcurrent_latch_select) begin
            oc_nxt = MFP_OC_HOLD;
          end else begin
            cnt_nxt = bump(cnt_r);
            if (cnt_nxt == `MFP_RETRY_LIMIT) begin
              oc_nxt = MFP_OC_HOLD;
            end else begin
              oc_nxt    = MFP_OC_WAIT;
              tmr_start = 1'b1;
            end
          end
        end
      end
      MFP_OC_WAIT: begin
        if (flt.tmr_done) begin
          if (oc_any) begin
            cnt_nxt = bump(cnt_r);
            if (cnt_nxt == `MFP_RETRY_LIMIT) begin
              oc_nxt = MFP_OC_HOLD;
            end else begin
              tmr_start = 1'b1;
            end
          end else begin
            oc_nxt  = MFP_OC_RUN;
            cnt_nxt = `MFP_CNT_RST;
          end
        end
      end
      MFP_OC_HOLD: begin
        if (speed_reapply) begin
          oc_nxt  = MFP_OC_RUN;
          cnt_nxt = `MFP_CNT_RST;
        end
      end
      default: begin
        oc_nxt  = MFP_OC_RUN;
        cnt_nxt = `MFP_CNT_RST;
      end
    endcase
  end

  // Overcurrent state and retry counter.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      oc_r  <= MFP_OC_RUN;
      cnt_r <= `MFP_CNT_RST;
    end else begin
      oc_r  <= oc_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************************************
  // Output stage and alert
  // ****************************************************************

  // Registered outputs follow the next-state values, so they line up with state.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      drive_en_r  <= `MFP_DRIVE_RST;
      stage_hiz_r <= `MFP_FLAG_RST;
      alert_oe_r  <= `MFP_FLAG_RST;
      oc_sd_r     <= `MFP_FLAG_RST;
      oc_lock_r   <= `MFP_FLAG_RST;
      alert_out_r <= 1'b0;
    end else begin
      drive_en_r  <= (oc_nxt == MFP_OC_RUN) & ~pump_uv_nxt & ~therm_nxt;
      stage_hiz_r <= pump_uv_nxt;
      alert_oe_r  <= pump_uv_nxt | therm_nxt | (oc_nxt != MFP_OC_RUN);
      oc_sd_r     <= (oc_nxt != MFP_OC_RUN);
      oc_lock_r   <= (oc_nxt == MFP_OC_HOLD);
      alert_out_r <= 1'b0;
    end
  end

  assign drive_en             = drive_en_r;
  assign stage_hiz            = stage_hiz_r;
  assign alert_out            = alert_out_r;
  assign alert_oe             = alert_oe_r;
  assign overcurrent_shutdown = oc_sd_r;
  assign overcurrent_lockout  = oc_lock_r;
  assign thermal_shutdown     = therm_r;
  assign retry_count          = cnt_r;

  // ****************************************************************
  // Checks
  // ****************************************************************

  property p_pump_hiz;
    @(posedge sys_clk) disable iff (srst)
      flt.pump_low |=> stage_hiz && !drive_en;
  endproperty
  a_pump_hiz: assert property (p_pump_hiz) else $error("pump uv not hiz");

  property p_pump_recover;
    @(posedge sys_clk) disable iff (srst)
      stage_hiz && !flt.pump_low && !flt.pump_ok |=> stage_hiz;
  endproperty
  a_pump_recover: assert property (p_pump_recover) else $error("pump uv left early");

  property p_alert_pump;
    @(posedge sys_clk) disable iff (srst)
      stage_hiz |-> alert_oe && !alert_out;
  endproperty
  a_alert_pump: assert property (p_alert_pump) else $error("alert off in pump uv");

  property p_oc_off;
    @(posedge sys_clk) disable iff (srst)
      oc_any && oc_r == MFP_OC_RUN |=> !drive_en;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("stages on after trip");

  property p_alert_fault;
    @(posedge sys_clk) disable iff (srst)
      overcurrent_shutdown || thermal_shutdown |-> alert_oe;
  endproperty
  a_alert_fault: assert property (p_alert_fault) else $error("alert off in fault");

  property p_latch_mode;
    @(posedge sys_clk) disable iff (srst)
      oc_any && oc_r == MFP_OC_RUN && overcurrent_latch_select
      |=> oc_r == MFP_OC_HOLD ##1 (oc_r == MFP_OC_HOLD || $past(speed_reapply));
  endproperty
  a_latch_mode: assert property (p_latch_mode) else $error("latch mode not held");

  property p_auto_retry;
    @(posedge sys_clk) disable iff (srst)
      oc_any && oc_r == MFP_OC_RUN && !overcurrent_latch_select && cnt_r == 4'h0
      |=> oc_r == MFP_OC_WAIT && cnt_r == 4'h1;
  endproperty
  a_auto_retry: assert property (p_auto_retry) else $error("auto retry missing");

  property p_lockout;
    @(posedge sys_clk) disable iff (srst)
      oc_r == MFP_OC_WAIT && flt.tmr_done && oc_any && cnt_r == 4'h7
      |=> oc_r == MFP_OC_HOLD && overcurrent_lockout;
  endproperty
  a_lockout: assert property (p_lockout) else $error("no lockout at eighth trip");

  property p_hold_stays;
    @(posedge sys_clk) disable iff (srst)
      oc_r == MFP_OC_HOLD && !speed_reapply |=> oc_r == MFP_OC_HOLD;
  endproperty
  a_hold_stays: assert property (p_hold_stays) else $error("lockout left early");

  property p_reapply;
    @(posedge sys_clk) disable iff (srst)
      oc_r == MFP_OC_HOLD && speed_reapply |=> oc_r == MFP_OC_RUN && cnt_r == 4'h0;
  endproperty
  a_reapply: assert property (p_reapply) else $error("reapply did not clear");

  property p_retry_clear;
    @(posedge sys_clk) disable iff (srst)
      oc_r == MFP_OC_WAIT && flt.tmr_done && !oc_any
      |=> oc_r == MFP_OC_RUN && cnt_r == 4'h0;
  endproperty
  a_retry_clear: assert property (p_retry_clear) else $error("counter not cleared");

  property p_tsd;
    @(posedge sys_clk) disable iff (srst)
      flt.temp_hot |=> thermal_shutdown && !drive_en;
  endproperty
  a_tsd: assert property (p_tsd) else $error("no thermal shutdown");

  property p_tsd_recover;
    @(posedge sys_clk) disable iff (srst)
      thermal_shutdown && flt.temp_cool && !flt.temp_hot |=> !thermal_shutdown;
  endproperty
  a_tsd_recover: assert property (p_tsd_recover) else $error("no thermal recovery");

endmodule

`default_nettype wire

//--- sim/mfp_plant_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Comparators of the supply side and the alert pull-up
// ****************************************************************
module mfp_plant_model (
  // Analog conditions set by the bench
  input  wire logic [15:0]        pump_mv,
  input  wire logic [8:0]         temp_c,
  input  wire mfp_pkg::mfp_lane_t amp_over,
  // Comparator indications toward the block
  output logic                    pump_low_raw,
  output logic                    pump_ok_raw,
  output logic                    temp_hot_raw,
  output logic                    temp_cool_raw,
  output mfp_pkg::mfp_lane_t      oc_raw,
  // Open-drain alert pin
  input  wire logic               alert_out,
  input  wire logic               alert_oe,
  output logic                    alert_pin
);
  // The two pump comparators leave a dead band so the block sees hysteresis.
  always_comb begin
    pump_low_raw = (pump_mv <= 16'h0CE4);
    pump_ok_raw  = (pump_mv > 16'h0E10);
  end

  // Junction temperature comparators, 170 C trip and 130 C release.
  always_comb begin
    temp_hot_raw  = (temp_c > 9'h0AA);
    temp_cool_raw = (temp_c <= 9'h082);
  end

  // Each transistor has its own current comparator.
  assign oc_raw = amp_over;

  // The pull-up holds the pin high whenever the block lets go of it.
  assign alert_pin = alert_oe ? alert_out : 1'b1;
endmodule

`default_nettype wire

//--- sim/mfp_fault_prot_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Self-checking bench for the fault protection block
// ****************************************************************
module mfp_fault_prot_tb;
  import mfp_pkg::*;
  localparam int unsigned BASE = 8;
  logic        sys_clk, srst, speed_command, overcurrent_latch_select;
  mfp_sel_t    off_period_select;
  logic [15:0] pump_mv;
  logic [8:0]  temp_c;
  mfp_lane_t   amp_over, oc_raw;
  logic        pump_low_raw, pump_ok_raw, temp_hot_raw, temp_cool_raw;
  logic        drive_en, stage_hiz, alert_out, alert_oe, alert_pin;
  logic        overcurrent_shutdown, overcurrent_lockout, thermal_shutdown;
  mfp_cnt_t    retry_count;
  int          errors, n_tests, seed, k, cnt, n;

  mfp_plant_model plant (.pump_mv(pump_mv), .temp_c(temp_c), .amp_over(amp_over),
    .pump_low_raw(pump_low_raw), .pump_ok_raw(pump_ok_raw), .temp_hot_raw(temp_hot_raw),
    .temp_cool_raw(temp_cool_raw), .oc_raw(oc_raw), .alert_out(alert_out),
    .alert_oe(alert_oe), .alert_pin(alert_pin));

  mfp_fault_prot #(.OFF_BASE_CYC(BASE)) dut (.sys_clk(sys_clk), .srst(srst),
    .pump_low_raw(pump_low_raw), .pump_ok_raw(pump_ok_raw), .temp_hot_raw(temp_hot_raw),
    .temp_cool_raw(temp_cool_raw), .oc_raw(oc_raw), .speed_command(speed_command),
    .overcurrent_latch_select(overcurrent_latch_select),
    .off_period_select(off_period_select), .drive_en(drive_en), .stage_hiz(stage_hiz),
    .alert_out(alert_out), .alert_oe(alert_oe),
    .overcurrent_shutdown(overcurrent_shutdown),
    .overcurrent_lockout(overcurrent_lockout), .thermal_shutdown(thermal_shutdown),
    .retry_count(retry_count));

  // Free-running 125 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Advances c edges and settles just after the last one.
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compares one flag.
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  // Compares the retry counter.
  task automatic chk_cnt(input mfp_cnt_t got, input mfp_cnt_t exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t retry count got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Checks drive, high impedance and the alert pin together.
  task automatic chk_out(input logic drv, input logic hiz, input logic pin);
    chk_bit(drive_en, drv, "drive enable");
    chk_bit(stage_hiz, hiz, "stage hiz");
    chk_bit(alert_pin, pin, "alert pin");
  endtask

  // Waits for drive enable to reach v under a bound, counting the cycles.
  task automatic wait_drive(input logic v, input int bound, output int used);
    used = 0;
    while (drive_en !== v && used < bound) begin
      cyc(1);
      used++;
    end
    if (drive_en !== v) begin
      errors++;
      $display("CHECK FAILED t=%0t drive enable wait timed out", $time);
      test_done();
    end
  endtask

  // Off period in cycles for a selector value.
  function automatic int off_cyc(input mfp_sel_t s);
    return BASE << s;
  endfunction

  // Reapplies the speed command with a stop cycle first.
  task automatic reapply();
    speed_command = 1'b0;
    cyc(1);
    speed_command = 1'b1;
    cyc(3);
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("CHECK FAILED t=%0t run limit reached", $time);
    test_done();
  end

  // Main sequence.
  initial begin
    errors = 0;
    n_tests = 0;
    seed = 32'h0589;
    srst = 1'b1;
    speed_command = 1'b1;
    overcurrent_latch_select = 1'b0;
    off_period_select = 2'h0;
    pump_mv = 16'h1388;
    temp_c = 9'h019;
    amp_over = 6'h00;
    cyc(4);
    chk_out(1'b0, 1'b0, 1'b1);
    chk_cnt(retry_count, 4'h0);
    srst = 1'b0;
    wait_drive(1'b1, 10, cnt);
    // Pump undervoltage, with the synchroniser delay and the dead band.
    pump_mv = 16'h0CE4;
    cyc(2);
    chk_bit(drive_en, 1'b1, "sync delay");
    cyc(1);
    chk_out(1'b0, 1'b1, 1'b0);
    pump_mv = 16'h0DAC;
    cyc(6);
    chk_out(1'b0, 1'b1, 1'b0);
    pump_mv = 16'h0E11;
    cyc(3);
    chk_out(1'b1, 1'b0, 1'b1);
    // Thermal shutdown and its hysteresis.
    temp_c = 9'h0AB;
    cyc(2);
    chk_bit(drive_en, 1'b1, "sync delay");
    cyc(1);
    chk_out(1'b0, 1'b0, 1'b0);
    chk_bit(thermal_shutdown, 1'b1, "thermal");
    temp_c = 9'h083;
    cyc(6);
    chk_bit(thermal_shutdown, 1'b1, "thermal hold");
    temp_c = 9'h082;
    cyc(3);
    chk_bit(thermal_shutdown, 1'b0, "thermal release");
    chk_bit(drive_en, 1'b1, "drive back");
    // One-cycle overcurrent on every lane, each selector value, automatic retry.
    for (k = 0; k < 6; k++) begin
      off_period_select = (k < 4) ? mfp_sel_t'(k) : mfp_sel_t'($random(seed));
      n = off_cyc(off_period_select);
      amp_over = mfp_lane_t'(1) << k;
      cyc(1);
      amp_over = 6'h00;
      cyc(2);
      chk_out(1'b0, 1'b0, 1'b0);
      chk_bit(overcurrent_shutdown, 1'b1, "oc shutdown");
      chk_cnt(retry_count, 4'h1);
      wait_drive(1'b1, n + 10, cnt);
      chk_bit(cnt == n + 1, 1'b1, "off period length");
      chk_cnt(retry_count, 4'h0);
      chk_bit(overcurrent_shutdown, 1'b0, "oc recovered");
    end
    // A re-application during the off period changes nothing.
    off_period_select = 2'h0;
    amp_over = mfp_lane_t'(1) << ($unsigned($random(seed)) % 6);
    cyc(1);
    amp_over = 6'h00;
    cyc(2);
    reapply();
    chk_bit(overcurrent_shutdown, 1'b1, "reapply in off period");
    chk_cnt(retry_count, 4'h1);
    wait_drive(1'b1, BASE + 10, cnt);
    // Persisting overcurrent locks out at the eighth trip in a row, not before.
    off_period_select = 2'h0;
    amp_over = mfp_lane_t'(1) << ($unsigned($random(seed)) % 6);
    cyc(2 + 7 * (BASE + 1));
    chk_bit(overcurrent_lockout, 1'b0, "lockout too early");
    chk_cnt(retry_count, 4'h7);
    cyc(1);
    chk_bit(overcurrent_lockout, 1'b1, "lockout");
    chk_cnt(retry_count, 4'h8);
    amp_over = 6'h00;
    cyc(off_cyc(2'h3));
    chk_out(1'b0, 1'b0, 1'b0);
    reapply();
    chk_bit(overcurrent_lockout, 1'b0, "lockout cleared");
    chk_cnt(retry_count, 4'h0);
    chk_bit(drive_en, 1'b1, "drive after reapply");
    // Latch mode holds after one trip; a reset clears it.
    overcurrent_latch_select = 1'b1;
    amp_over = mfp_lane_t'(1) << ($unsigned($random(seed)) % 6);
    cyc(1);
    amp_over = 6'h00;
    cyc(2);
    chk_bit(overcurrent_lockout, 1'b1, "latched");
    chk_cnt(retry_count, 4'h0);
    cyc(2 * off_cyc(2'h3));
    chk_out(1'b0, 1'b0, 1'b0);
    // Re-applying the speed command releases the latch; then latch once more.
    reapply();
    chk_bit(overcurrent_lockout, 1'b0, "latch released");
    chk_bit(drive_en, 1'b1, "drive after release");
    amp_over = mfp_lane_t'(1) << ($unsigned($random(seed)) % 6);
    cyc(1);
    amp_over = 6'h00;
    cyc(2);
    chk_bit(overcurrent_lockout, 1'b1, "latched again");
    srst = 1'b1;
    cyc(3);
    srst = 1'b0;
    wait_drive(1'b1, 10, cnt);
    chk_bit(overcurrent_lockout, 1'b0, "reset clears latch");
    test_done();
  end
endmodule

`default_nettype wire
